// ### logic/ssp_top.sv
// Four-line serial port, master or slave, with its register file
// Operation
// - full duplex, every bit out matched by a bit in; master or slave
// - only the master starts transfers and drives the serial clock
// - select enable 1 uses the select pin, 0 leaves it floating
// - port enable bit in control 0 switches the whole port
// - three-bit mode field chooses four-line or two-wire function
// - one shift data register holds outgoing and incoming byte
// - software loads byte before transfer and reads it afterwards
// - bit order bit in control 2 picks MSB or LSB first
// - software chooses rising or falling capture edge
// - control register 1 has no effect on the four-line port
// - control 0 holds enable and clock rate selection
// - control 2 holds bit order and collision flag, doubles as address
// - pin states follow master or slave, select enable and port enable
// - enabled input pins take pull-up from pull-high controls
// - lines are data in, data out, serial clock, select low
// - codes 000-100 master rates, 101 slave, 110 two-wire, 111 none
// - done flag sets at end of each byte, held until cleared
// - data write during transfer is dropped and sets collision flag
// - idle level bit 1 idles clock low; edge bit picks sampling edge
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_top (
  input wire logic clock, // System clock, 25 MHz
  input wire logic resetn, // Async reset, active low
  input wire logic [2:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic sub_tick, // Slow clock half-period pulse
  input wire logic timer_tick, // Timer match pulse
  input wire logic sdi_in, // Serial data input
  output logic sdo_out, // Serial data output
  output logic sdo_oe, // Data output enable
  input wire logic sck_in, // Serial clock pin level
  output logic sck_out, // Serial clock drive
  output logic sck_oe, // Serial clock enable
  input wire logic slave_select_n_in, // Select pin level
  output logic slave_select_n_out, // Select pin drive
  output logic slave_select_n_oe, // Select pin enable
  input wire logic [3:0] pull_high_ctrl, // Pull-high controls per pin
  output logic [3:0] pull_up_en // Pull-up enables per pin
);
  import ssp_pkg::*;

  // Reset images, so that single fields can be sliced out of them
  localparam logic [7:0] ctrl0_rst = `SSP_CTRL0_RST;
  localparam logic [7:0] ctrl2_rst = `SSP_CTRL2_RST;

  // Register fields
  ssp_mode_t mode_select_field;
  logic [1:0] debounce_sel;
  logic port_enable_bit;
  logic incomplete_flag;
  logic [7:0] two_wire_control_register;
  logic [1:0] spare_bits;
  logic clock_idle_level;
  logic capture_edge_select;
  logic bit_order_select;
  logic select_pin_enable;
  logic write_collision_flag;
  logic transfer_done_flag;
  logic [7:0] shift_data_register;

  // Transfer state
  ssp_state_t state;
  logic [2:0] bit_count;
  logic sample_bit;

  // Decodes
  logic wr_c0;
  logic wr_c1;
  logic wr_c2;
  logic wr_data;
  logic is_master;
  logic is_slave;
  logic spi_on;
  logic idle_sck;
  logic selected;
  logic m_tick;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic lead;
  logic trail;
  logic edge_ok;
  logic shift_bit;
  logic [7:0] shifted;
  logic done_byte;
  logic start;
  logic collide;
  logic slave_abort;

  // Shift one bit in at the far end from the outgoing bit
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                          input logic msb_first);
    shift_in = msb_first ? {d[6:0], b} : {b, d[7:1]};
  endfunction

  // Bit that leaves next for the chosen order
  function automatic logic first_bit(input logic [7:0] d, input logic msb_first);
    first_bit = msb_first ? d[7] : d[0];
  endfunction

  // Register strobes
  assign wr_c0 = reg_write && reg_addr == `SSP_ADDR_CTRL0;
  assign wr_c1 = reg_write && reg_addr == `SSP_ADDR_CTRL1;
  assign wr_c2 = reg_write && reg_addr == `SSP_ADDR_CTRL2;
  assign wr_data = reg_write && reg_addr == `SSP_ADDR_DATA;

  assign is_master = port_enable_bit && mode_select_field <= SSP_M_TIMER;
  assign is_slave = port_enable_bit && mode_select_field == SSP_M_SLAVE;
  // two-wire and unused codes keep the port off
  assign spi_on = is_master || is_slave;

  assign idle_sck = ~clock_idle_level;

  // select pin ignored when its enable is low
  assign selected = !select_pin_enable || !slave_select_n_in;

  // master rate from the mode field
  ssp_clkdiv u_clkdiv (
    .clock(clock),
    .resetn(resetn),
    .run(is_master && state == SSP_BUSY),
    .mode(mode_select_field),
    .sub_tick(sub_tick),
    .timer_tick(timer_tick),
    .tick(m_tick)
  );

  // slave follows the external clock only
  ssp_sck_edge u_sck_edge (
    .clock(clock),
    .resetn(resetn),
    .sck_in(sck_in),
    .idle_level(idle_sck),
    .active(is_slave && selected),
    .lead(s_lead),
    .trail(s_trail)
  );

  // Master edges from its own clock level
  assign m_lead = m_tick && sck_out == idle_sck;
  assign m_trail = m_tick && sck_out != idle_sck;
  assign lead = is_master ? m_lead : s_lead;
  assign trail = is_master ? m_trail : s_trail;
  assign edge_ok = is_master ? state == SSP_BUSY : is_slave;

  // edge bit picks capture on leading or trailing edge
  assign shift_bit = capture_edge_select ? sample_bit : sdi_in;
  assign shifted = shift_in(shift_data_register, shift_bit, bit_order_select);

  // byte ends on the eighth trailing edge
  assign done_byte = edge_ok && trail && bit_count == `SSP_LAST_BIT;

  // data write starts a master transfer
  assign start = wr_data && is_master && state == SSP_IDLE;
  assign collide = wr_data && state == SSP_BUSY;
  assign slave_abort = is_slave && select_pin_enable && slave_select_n_in
                       && state == SSP_BUSY;

  // Transfer state machine
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SSP_IDLE;
    end else begin
      case (state)
        SSP_IDLE: begin
          if (start || (is_slave && s_lead && !done_byte)) begin
            state <= SSP_BUSY;
          end
        end
        SSP_BUSY: begin
          if (!spi_on || done_byte || slave_abort) begin
            state <= SSP_IDLE;
          end
        end
        default: state <= SSP_IDLE;
      endcase
    end
  end

  // bit counter, cleared with the port off, on a slave abort and at a master start
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_count <= 3'h0;
    end else if (!spi_on || slave_abort || start) begin
      bit_count <= 3'h0;
    end else if (edge_ok && trail) begin
      bit_count <= bit_count + 3'h1;
    end
  end

  // input sample held for the shift on the trailing edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sample_bit <= 1'b0;
    end else if (edge_ok && lead && capture_edge_select) begin
      sample_bit <= sdi_in;
    end
  end

  // one register for send and receive
  // software load when idle, received byte read back
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_data_register <= `SSP_DATA_RST;
    end else if (wr_data && state == SSP_IDLE) begin
      shift_data_register <= reg_wdata;
    end else if (edge_ok && trail) begin
      shift_data_register <= shifted;
    end
  end

  // data out changes on the edge opposite the capture edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sdo_out <= 1'b0;
    end else if (start) begin
      sdo_out <= first_bit(reg_wdata, bit_order_select);
    end else if (edge_ok && lead && !capture_edge_select) begin
      sdo_out <= first_bit(shift_data_register, bit_order_select);
    end else if (edge_ok && trail && capture_edge_select) begin
      sdo_out <= first_bit(shifted, bit_order_select);
    end else if (state == SSP_IDLE && !(edge_ok && lead)) begin
      sdo_out <= first_bit(shift_data_register, bit_order_select);
    end
  end

  // parked at idle level between transfers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_out <= 1'b1;
    end else if (is_master && state == SSP_BUSY) begin
      if (m_tick) begin
        sck_out <= ~sck_out;
      end
    end else begin
      sck_out <= idle_sck;
    end
  end

  // three driven lines, each with its own drive enable; clock and data out here
  // pin directions from role and enables
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sck_oe <= is_master;
      sdo_oe <= is_master || (is_slave && selected);
    end
  end

  // select driven only with its enable set
  // single select, low while the master transfers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      slave_select_n_oe <= 1'b0;
      slave_select_n_out <= 1'b1;
    end else begin
      slave_select_n_oe <= is_master && select_pin_enable;
      // Falls with the load, a cycle ahead of the earliest clock edge
      slave_select_n_out <= !(is_master && (state == SSP_BUSY || start));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pull_up_en <= 4'h0;
    end else begin
      pull_up_en[`SSP_PIN_SDO] <= 1'b0;
      pull_up_en[`SSP_PIN_SDI] <= spi_on && pull_high_ctrl[`SSP_PIN_SDI];
      pull_up_en[`SSP_PIN_SCK] <= is_slave && pull_high_ctrl[`SSP_PIN_SCK];
      pull_up_en[`SSP_PIN_SCS] <= is_slave && select_pin_enable
                                  && pull_high_ctrl[`SSP_PIN_SCS];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_select_field <= ssp_mode_t'(ctrl0_rst[`SSP_C0_MODE_HI:`SSP_C0_MODE_LO]);
      debounce_sel <= ctrl0_rst[`SSP_C0_DBC_HI:`SSP_C0_DBC_LO];
      port_enable_bit <= ctrl0_rst[`SSP_C0_EN];
    end else if (wr_c0) begin
      mode_select_field <= ssp_mode_t'(reg_wdata[`SSP_C0_MODE_HI:`SSP_C0_MODE_LO]);
      debounce_sel <= reg_wdata[`SSP_C0_DBC_HI:`SSP_C0_DBC_LO];
      port_enable_bit <= reg_wdata[`SSP_C0_EN];
    end
  end

  // Incomplete flag, select released mid-byte; set beats clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      incomplete_flag <= ctrl0_rst[`SSP_C0_ICF];
    end else if (slave_abort) begin
      incomplete_flag <= 1'b1;
    end else if (wr_c0) begin
      incomplete_flag <= reg_wdata[`SSP_C0_ICF];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      two_wire_control_register <= `SSP_CTRL1_RST;
    end else if (wr_c1) begin
      two_wire_control_register <= reg_wdata;
    end
  end

  // control register 2 fields, also the two-wire address
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      spare_bits <= ctrl2_rst[`SSP_C2_SPARE_HI:`SSP_C2_SPARE_LO];
      clock_idle_level <= ctrl2_rst[`SSP_C2_IDLE];
      capture_edge_select <= ctrl2_rst[`SSP_C2_EDGE];
      bit_order_select <= ctrl2_rst[`SSP_C2_ORDER];
      select_pin_enable <= ctrl2_rst[`SSP_C2_SELECT_PIN_ENABLE];
    end else if (wr_c2) begin
      spare_bits <= reg_wdata[`SSP_C2_SPARE_HI:`SSP_C2_SPARE_LO];
      clock_idle_level <= reg_wdata[`SSP_C2_IDLE];
      capture_edge_select <= reg_wdata[`SSP_C2_EDGE];
      bit_order_select <= reg_wdata[`SSP_C2_ORDER];
      select_pin_enable <= reg_wdata[`SSP_C2_SELECT_PIN_ENABLE];
    end
  end

  // done flag, set beats software clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      transfer_done_flag <= ctrl2_rst[`SSP_C2_TRF];
    end else if (done_byte) begin
      transfer_done_flag <= 1'b1;
    end else if (wr_c2) begin
      transfer_done_flag <= reg_wdata[`SSP_C2_TRF];
    end
  end

  // collision flag, set beats software clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      write_collision_flag <= ctrl2_rst[`SSP_C2_WRITE_COLLISION_FLAG];
    end else if (collide) begin
      write_collision_flag <= 1'b1;
    end else if (wr_c2) begin
      write_collision_flag <= reg_wdata[`SSP_C2_WRITE_COLLISION_FLAG];
    end
  end

  // Read data for one cycle after the strobe, zero otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `SSP_ADDR_CTRL0: reg_rdata <= {mode_select_field, 1'b0, debounce_sel,
                                       port_enable_bit, incomplete_flag};
        `SSP_ADDR_DATA: reg_rdata <= shift_data_register;
        `SSP_ADDR_CTRL2: reg_rdata <= {spare_bits, clock_idle_level, capture_edge_select,
                                       bit_order_select, select_pin_enable,
                                       write_collision_flag, transfer_done_flag};
        `SSP_ADDR_CTRL1: reg_rdata <= two_wire_control_register;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule // ssp_top
`default_nettype wire

// ### logic/ssp_params.svh
// Register map, field positions, reset values and rate counts of the serial port
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Register addresses
`define SSP_ADDR_CTRL0 3'h0
`define SSP_ADDR_DATA 3'h1
`define SSP_ADDR_CTRL2 3'h2
`define SSP_ADDR_CTRL1 3'h3

// Control register 0 fields
`define SSP_C0_MODE_HI 7
`define SSP_C0_MODE_LO 5
`define SSP_C0_DBC_HI 3
`define SSP_C0_DBC_LO 2
`define SSP_C0_EN 1
`define SSP_C0_ICF 0

// Control register 2 fields
`define SSP_C2_SPARE_HI 7
`define SSP_C2_SPARE_LO 6
`define SSP_C2_IDLE 5
`define SSP_C2_EDGE 4
`define SSP_C2_ORDER 3
`define SSP_C2_SELECT_PIN_ENABLE 2
`define SSP_C2_WRITE_COLLISION_FLAG 1
`define SSP_C2_TRF 0

// Reset values
`define SSP_CTRL0_RST 8'he0
`define SSP_CTRL1_RST 8'h00
`define SSP_CTRL2_RST 8'h00
`define SSP_DATA_RST 8'h00

// Half-period of the serial clock in system cycles for each divided rate
`define SSP_HALF_DIV4 6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20

// Last bit index of a byte
`define SSP_LAST_BIT 3'h7

// Pull-up enable positions
`define SSP_PIN_SDO 0
`define SSP_PIN_SDI 1
`define SSP_PIN_SCK 2
`define SSP_PIN_SCS 3

`endif

// ### logic/ssp_pkg.sv
// Types shared by the serial port modules
`default_nettype none
package ssp_pkg;
  // Operating mode field codes
  typedef enum logic [2:0] {
    SSP_M_DIV4 = 3'h0,
    SSP_M_DIV16 = 3'h1,
    SSP_M_DIV64 = 3'h2,
    SSP_M_SUB = 3'h3,
    SSP_M_TIMER = 3'h4,
    SSP_M_SLAVE = 3'h5,
    SSP_M_TWI = 3'h6,
    SSP_M_NONE = 3'h7
  } ssp_mode_t;

  // Transfer state, one-hot
  typedef enum logic [1:0] {
    SSP_IDLE = 2'h1,
    SSP_BUSY = 2'h2
  } ssp_state_t;
endpackage
`default_nettype wire

// ### logic/ssp_clkdiv.sv
// Half-period tick generator for the master serial clock
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_clkdiv (
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic run, // Master transfer running
  input wire ssp_pkg::ssp_mode_t mode, // Rate selection
  input wire logic sub_tick, // Slow clock half-period pulse
  input wire logic timer_tick, // Timer match pulse
  output logic tick // Half-period pulse
);
  import ssp_pkg::*;

  logic [5:0] count;
  logic [5:0] half;

  // Half-period length for divided rates
  always_comb begin
    case (mode)
      SSP_M_DIV4: half = `SSP_HALF_DIV4;
      SSP_M_DIV16: half = `SSP_HALF_DIV16;
      default: half = `SSP_HALF_DIV64;
    endcase
  end

  // Divider counter, held at zero between transfers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= 6'h00;
    end else if (!run || count == half - 6'h01) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

  // Tick source per mode
  always_comb begin
    case (mode)
      SSP_M_SUB: tick = run & sub_tick;
      SSP_M_TIMER: tick = run & timer_tick;
      default: tick = run && count == half - 6'h01;
    endcase
  end
endmodule // ssp_clkdiv
`default_nettype wire

// ### logic/ssp_sck_edge.sv
// Leading and trailing edge detector for an incoming serial clock
`timescale 1ns/10ps
`default_nettype none
module ssp_sck_edge (
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic sck_in, // Serial clock pin level
  input wire logic idle_level, // Level of an inactive clock
  input wire logic active, // Slave selected and enabled
  output logic lead, // Edge leaving idle level
  output logic trail // Edge returning to idle level
);
  logic prev;

  // Last sampled level, parked at idle while inactive
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      // Parked high, the idle level of the clock out of reset
      prev <= 1'b1;
    end else begin
      prev <= active ? sck_in : idle_level;
    end
  end

  assign lead = active && prev == idle_level && sck_in != idle_level;
  assign trail = active && prev != idle_level && sck_in == idle_level;
endmodule // ssp_sck_edge
`default_nettype wire

// ### tb/ssp_chk.sv
// Port-level assertions for the serial port
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module ssp_chk (
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic [2:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic sub_tick, // Slow tick
  input wire logic timer_tick, // Timer tick
  input wire logic sdi_in, // Data in
  input wire logic sdo_out, // Data out
  input wire logic sdo_oe, // Data enable
  input wire logic sck_in, // Clock in
  input wire logic sck_out, // Clock out
  input wire logic sck_oe, // Clock enable
  input wire logic slave_select_n_in, // Select in
  input wire logic slave_select_n_out, // Select out
  input wire logic slave_select_n_oe, // Select enable
  input wire logic [3:0] pull_high_ctrl, // Pull controls
  input wire logic [3:0] pull_up_en // Pull enables
);
  logic [4:0] toggles;
  logic sck_q;
  // Count clock toggles inside a select frame
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      toggles <= 5'h00;
      sck_q <= 1'b1;
    end else begin
      sck_q <= sck_out;
      toggles <= slave_select_n_out ? 5'h00 : toggles + {4'h0, sck_out ^ sck_q};
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_sel_needs_clk: assert property (slave_select_n_oe |-> sck_oe)
    else $error("select driven without clock drive");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_pull_follow: assert property (
    !pull_up_en[`SSP_PIN_SDO] && (pull_up_en & ~$past(pull_high_ctrl)) == 4'h0)
    else $error("pull-up without pull-high control");
  a_clk_quiet: assert property (
    slave_select_n_oe && slave_select_n_out && $past(slave_select_n_out) && !$past(reg_write)
    && !$past(reg_write, 2) && !$past(reg_write, 3) |-> $stable(sck_out))
    else $error("clock moved outside frame");
  a_eight_bits: assert property (
    $rose(slave_select_n_out) && slave_select_n_oe |-> toggles == 5'h10)
    else $error("frame without sixteen clock toggles");
  a_sdo_driven: assert property (sck_oe && !slave_select_n_out |-> sdo_oe)
    else $error("data out not driven in frame");
  a_sdo_on_edge: assert property (
    sck_oe && !slave_select_n_out && !$past(slave_select_n_out) && toggles < 5'h10
    |-> $stable(sdo_out) || $changed(sck_out))
    else $error("data out moved without clock edge");
  a_off_float: assert property (
    reg_write && reg_addr == `SSP_ADDR_CTRL0 && !reg_wdata[`SSP_C0_EN] ##1 !reg_write
    |-> ##1 !sck_oe && !sdo_oe && !slave_select_n_oe)
    else $error("pins driven after port off");
endmodule // ssp_chk
`default_nettype wire

// ### tb/ssp_peer.sv
// Behavioural outside slave answering a master transfer
`timescale 1ns/10ps
`default_nettype none
module ssp_peer (
  input wire logic sck, // Clock wire
  input wire logic sdo, // Data from port
  input wire logic ssn, // Select wire
  input wire logic idle_hi, // Clock idle level
  input wire logic edge1, // Capture on leading edge
  input wire logic msb, // MSB first
  input wire logic load, // Any change loads tx
  input wire logic [7:0] tx, // Byte to send
  output var logic sdi, // Data to port
  output var logic [7:0] rx // Byte received
);
  logic [7:0] sh;
  int n;
  initial begin
    sdi = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
    n = 8;
  end
  always @(load) begin
    sh = tx;
    n = 0;
    if (edge1) sdi = msb ? tx[7] : tx[0];
  end
  always @(sck) begin
    if (n >= 8 || ssn) begin
      sdi = ~sdi;
    end else if ((sck != idle_hi) == edge1) begin
      rx = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
      n = n + 1;
    end else begin
      if (edge1) sh = msb ? sh << 1 : sh >> 1;
      sdi = msb ? sh[7] : sh[0];
      if (!edge1) sh = msb ? sh << 1 : sh >> 1;
    end
  end
endmodule // ssp_peer
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the four-line serial port
`timescale 1ns/10ps
`default_nettype none
`include "ssp_params.svh"
module tb;
  logic clock, resetn, reg_write, reg_read, sub_tick, timer_tick, sdo_out, sdo_oe;
  logic sck_out, sck_oe, slave_select_n_out, slave_select_n_oe, rd_d, slv;
  logic tb_sck, tb_ssn, tb_sdi, peer_sdi, peer_load, idle_hi, edge1, msb_first;
  logic [1:0] tick_n;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, peer_tx, peer_rx, mbyte, c2;
  logic [3:0] pull_high_ctrl, pull_up_en;
  logic [7:0] expq[$];
  int failures, total_checks;
  wire logic sck_w = sck_oe ? sck_out : tb_sck;
  wire logic ssn_w = slave_select_n_oe ? slave_select_n_out : tb_ssn;
  wire logic sdi_in = slv ? tb_sdi : peer_sdi;
  ssp_top ssp_top_i (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .sub_tick, .timer_tick, .sdi_in, .sdo_out, .sdo_oe, .sck_in(sck_w), .sck_out, .sck_oe,
    .slave_select_n_in(ssn_w), .slave_select_n_out, .slave_select_n_oe, .pull_high_ctrl,
    .pull_up_en);
  ssp_peer ssp_peer_i (.sck(sck_w), .sdo(sdo_out), .ssn(ssn_w), .idle_hi, .edge1,
    .msb(msb_first), .load(peer_load), .tx(peer_tx), .sdi(peer_sdi), .rx(peer_rx));
  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Slow and timer pulses, read tracking
  always @(posedge clock) begin
    tick_n <= (tick_n == 2'h2) ? 2'h0 : tick_n + 2'h1;
    sub_tick <= (tick_n == 2'h0);
    timer_tick <= (tick_n == 2'h1);
    rd_d <= reg_read;
  end
  // Compare each read answer with the oldest note
  always @(negedge clock) begin
    if (rd_d === 1'b1) chk("reg_rdata", expq.pop_front(), reg_rdata);
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [2:0] a, logic [7:0] e);
    expq.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_hi();
    int n;
    n = 0;
    while (slave_select_n_out !== 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    chk("select wait", 8'h01, {7'h0, slave_select_n_out});
    if (n >= 2000) end_of_test();
  endtask
  task automatic sbits(int n, logic [7:0] d);
    for (int b = 7; b > 7 - n; b--) begin
      tb_sck <= 1'b0;
      tb_sdi <= d[b];
      cyc(4);
      chk("slave sdo", {7'h0, mbyte[b]}, {7'h0, sdo_out});
      tb_sck <= 1'b1;
      cyc(4);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {reg_write, reg_read, sub_tick, timer_tick, slv, peer_load, tb_sdi, resetn} = 8'h00;
    {tb_sck, tb_ssn, idle_hi, edge1, msb_first} = 5'h1c;
    {reg_addr, reg_wdata, tick_n, rd_d} = 14'h0000;
    peer_tx = 8'h00;
    failures = 0;
    total_checks = 0;
    void'($urandom(41734));
    pull_high_ctrl = 4'($urandom);
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(3'(a), (a == 0) ? 8'he0 : 8'h00);
    chk("pins off", 8'h00, {1'b0, sck_oe, sdo_oe, slave_select_n_oe, pull_up_en});
    wr(3'h6, 8'hff);
    wr(`SSP_ADDR_CTRL0, 8'h1c);
    rd(3'h6, 8'h00);
    rd(`SSP_ADDR_CTRL0, 8'h0c);
    // Master bytes: each idle level, edge and order, then each rate
    for (int i = 0; i < 12; i++) begin
      c2 = {2'(i), 3'(i), 3'b100};
      {idle_hi, edge1, msb_first} = {~c2[5], c2[4], c2[3]};
      peer_tx = 8'($urandom);
      mbyte = 8'($urandom);
      wr(`SSP_ADDR_CTRL1, 8'($urandom));
      wr(`SSP_ADDR_CTRL0, {(i < 8) ? 3'h0 : 3'(i - 7), 5'h02});
      wr(`SSP_ADDR_CTRL2, c2);
      cyc(3);
      chk("sck idle", {7'h0, idle_hi}, {7'h0, sck_out});
      chk("select oe", 8'h01, {7'h0, slave_select_n_oe});
      chk("sdi pull", {7'h0, pull_high_ctrl[1]}, {7'h0, pull_up_en[1]});
      peer_load = ~peer_load;
      wr(`SSP_ADDR_DATA, mbyte);
      wr(`SSP_ADDR_DATA, ~mbyte);
      cyc(1);
      wait_hi();
      rd(`SSP_ADDR_CTRL2, c2 | 8'h03);
      rd(`SSP_ADDR_DATA, peer_tx);
      chk("peer rx", mbyte, peer_rx);
      wr(`SSP_ADDR_CTRL2, c2);
      rd(`SSP_ADDR_CTRL2, c2);
    end
    // Port off, two-wire and unused codes: nothing driven, no frame
    for (int k = 0; k < 3; k++) begin
      wr(`SSP_ADDR_CTRL0, (k == 0) ? 8'h00 : {2'b11, 1'(k - 1), 5'h02});
      cyc(1);
      wr(`SSP_ADDR_DATA, mbyte);
      cyc(3);
      chk("pins off", 8'h00, {5'h0, sck_oe, sdo_oe, slave_select_n_oe});
      chk("no frame", 8'h01, {7'h0, slave_select_n_out});
    end
    rd(`SSP_ADDR_DATA, mbyte);
    // Slave byte from an outside master, then an aborted byte
    wr(`SSP_ADDR_CTRL0, 8'ha2);
    wr(`SSP_ADDR_CTRL2, 8'h0c);
    mbyte = 8'($urandom);
    wr(`SSP_ADDR_DATA, mbyte);
    slv <= 1'b1;
    tb_ssn <= 1'b0;
    cyc(4);
    chk("slave pins", 8'h02, {5'h0, sck_oe, sdo_oe, slave_select_n_oe});
    chk("slave pulls", {4'h0, pull_high_ctrl[3:1], 1'b0}, {4'h0, pull_up_en});
    sbits(8, peer_tx);
    tb_ssn <= 1'b1;
    cyc(4);
    rd(`SSP_ADDR_DATA, peer_tx);
    rd(`SSP_ADDR_CTRL2, 8'h0d);
    wr(`SSP_ADDR_CTRL2, 8'h0c);
    wr(`SSP_ADDR_DATA, mbyte);
    tb_ssn <= 1'b0;
    cyc(4);
    sbits(3, peer_tx);
    tb_ssn <= 1'b1;
    cyc(4);
    rd(`SSP_ADDR_CTRL0, 8'ha3);
    cyc(2);
    end_of_test();
  end
endmodule // tb
bind ssp_top ssp_chk ssp_chk_i (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .sub_tick, .timer_tick, .sdi_in, .sdo_out, .sdo_oe, .sck_in, .sck_out, .sck_oe,
  .slave_select_n_in, .slave_select_n_out, .slave_select_n_oe, .pull_high_ctrl, .pull_up_en);
`default_nettype wire
